// [pdp_byte_packer.sv]
// selects the descriptor byte at a given index
`timescale 1ns/1ns
module pdp_byte_packer (
  pdp_if.packer bus
);
  import pdp_pkg::*;
  wire [7:0] payIdx = bus.byteIdx - HDR_BYTES;
  wire constrOut = bus.video.constrained | ~bus.video.legacyOnlyVideoFlag;
  wire [7:0] videoB0 = {bus.video.multiRate, bus.video.rateCode,
    bus.video.legacyOnlyVideoFlag, constrOut, bus.video.still};
  wire [7:0] videoB2 = {bus.video.chroma, bus.video.rateExt, RSV5};
  wire [7:0] videoPay = (payIdx == 8'h00) ? videoB0 :
    (payIdx == 8'h01) ? bus.video.profLevel : videoB2;
  wire [7:0] audioPay = {bus.audio.freeFormat, bus.audio.audioIdentityBit,
    bus.audio.layer, bus.audio.variableRate, RSV3};
  wire [7:0] hierBytes [4];
  assign hierBytes[0] = {RSV4, bus.hier.hierType};
  assign hierBytes[1] = {RSV2, bus.hier.layerIdx};
  assign hierBytes[2] = {RSV2, bus.hier.embedded};
  assign hierBytes[3] = {RSV2, bus.hier.channel};
  wire [7:0] fmtBytes [4];
  assign fmtBytes[0] = bus.fmtId[31:24];
  assign fmtBytes[1] = bus.fmtId[23:16];
  assign fmtBytes[2] = bus.fmtId[15:8];
  assign fmtBytes[3] = bus.fmtId[7:0];
  wire [7:0] regPay = (payIdx < LEN_REG_BASE) ? fmtBytes[payIdx[1:0]] :
    bus.extraByte;
  wire [7:0] videoLen = bus.video.legacyOnlyVideoFlag ? LEN_VIDEO_LONG :
    LEN_VIDEO_SHORT;
  assign bus.descLen = (bus.kind == PDP_VIDEO) ? videoLen :
    (bus.kind == PDP_AUDIO) ? LEN_AUDIO :
    (bus.kind == PDP_HIER) ? LEN_HIER :
    LEN_REG_BASE + {4'h0, bus.extraCnt};
  wire [7:0] payByte = (bus.kind == PDP_VIDEO) ? videoPay :
    (bus.kind == PDP_AUDIO) ? audioPay :
    (bus.kind == PDP_HIER) ? hierBytes[payIdx[1:0]] : regPay;
  assign bus.curByte = (bus.byteIdx == 8'h00) ? pdp_tag(bus.kind) :
    (bus.byteIdx == 8'h01) ? bus.descLen : payByte;
endmodule

// [pdp_descriptor_builder.sv]
// builds program descriptors from register fields and streams their bytes
// Operation
// - tag byte, then length byte, then data
// - length counts bytes after the length byte
// - video layout, extra bytes follow legacy flag
// - constrained forced high when legacy flag low
// - profile and chroma copied unchanged
// - audio layout: flags, layer, rate, reserved
// - identity bit and layer copied unchanged
// - hierarchy layout: type, three six-bit fields
// - layer index unique within one program
// - registration: format id then extra bytes
// - format id and extra bytes sent verbatim
`timescale 1ns/1ns
module pdp_descriptor_builder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  output logic [7:0] outData,
  output logic outValid,
  output logic outFirst,
  output logic outLast,
  input wire logic outReady
);
  import pdp_pkg::*;

  typedef enum logic {ST_IDLE, ST_SEND} pdp_state_e;

  pdp_if ifc();

  pdp_state_e stateReg;
  pdp_state_e stateNext;
  pdp_kind_e kindReg;
  pdp_kind_e kindNext;
  pdp_video_s videoReg;
  pdp_audio_s audioReg;
  pdp_hier_s hierReg;
  logic [31:0] fmtReg;
  logic [3:0] extraCntReg;
  logic [7:0] extraMem [8];
  logic [7:0] idxReg;
  logic [7:0] idxNext;
  logic [7:0] dataReg;
  logic refusedReg;
  logic [15:0] countReg;
  logic [31:0] rdReg;
  logic isDup;

  // register decode
  wire idle = (stateReg == ST_IDLE);
  wire sending = (stateReg == ST_SEND);
  wire wrCtrl = regWrStb && (regAddr == ADDR_CTRL);
  wire wrStat = regWrStb && (regAddr == ADDR_STAT);
  wire wrVideo = regWrStb && (regAddr == ADDR_VIDEO);
  wire wrAudio = regWrStb && (regAddr == ADDR_AUDIO);
  wire wrHier = regWrStb && (regAddr == ADDR_HIER);
  wire wrFmt = regWrStb && (regAddr == ADDR_FMT);
  wire wrExtra = regWrStb && (regAddr == ADDR_EXTRA);
  wire wrField = wrVideo || wrAudio || wrHier || wrFmt || wrExtra;
  wire startReq = wrCtrl && regWrData[CTRL_START];
  wire newProg = wrCtrl && regWrData[CTRL_NEWPROG];
  wire clrExtra = wrCtrl && regWrData[CTRL_CLREXTRA] && idle;
  wire [1:0] wrKind = regWrData[CTRL_KIND_LSB +: 2];
  wire wrHierKind = (pdp_kind_e'(wrKind) == PDP_HIER);
  wire dupHier = wrHierKind && isDup;
  wire go = startReq && idle && !dupHier;
  wire refuseEvt = (startReq && !go) || (wrField && !idle);
  wire pushExtra = wrExtra && idle && (extraCntReg < EXTRA_MAX);
  wire clrRefused = wrStat && regWrData[STAT_REFUSED];

  // byte sequencing
  wire accept = sending && outReady;
  wire [7:0] lastIdx = ifc.descLen + 8'h01;
  wire lastByte = (idxReg == lastIdx);
  wire done = accept && lastByte;
  wire commitLayer = done && (kindReg == PDP_HIER);
  wire [7:0] extraOff = idxNext - EXTRA_FIRST;

  assign kindNext = (wrCtrl && idle) ? pdp_kind_e'(wrKind) : kindReg;
  assign idxNext = go ? 8'h00 :
    (accept && !lastByte) ? idxReg + 8'h01 : idxReg;
  assign stateNext = go ? ST_SEND : done ? ST_IDLE : stateReg;

  assign ifc.kind = kindNext;
  assign ifc.video = videoReg;
  assign ifc.audio = audioReg;
  assign ifc.hier = hierReg;
  assign ifc.fmtId = fmtReg;
  assign ifc.extraCnt = extraCntReg;
  assign ifc.extraByte = extraMem[extraOff[2:0]];
  assign ifc.byteIdx = idxNext;

  pdp_byte_packer u_packer (
    .bus(ifc)
  );

  pdp_layer_check u_layers (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clearTable(newProg),
    .commit(commitLayer),
    .queryIdx(hierReg.layerIdx),
    .isDup(isDup)
  );

  // read mux
  wire [31:0] statWord = {30'h0, refusedReg, sending};
  wire [31:0] ctrlWord = {29'h0, kindReg, 1'b0};
  wire [31:0] rdMux = (regAddr == ADDR_CTRL) ? ctrlWord :
    (regAddr == ADDR_STAT) ? statWord :
    (regAddr == ADDR_VIDEO) ? {13'h0, videoReg} :
    (regAddr == ADDR_AUDIO) ? {27'h0, audioReg} :
    (regAddr == ADDR_HIER) ? {10'h0, hierReg} :
    (regAddr == ADDR_FMT) ? fmtReg :
    (regAddr == ADDR_EXTRA) ? {28'h0, extraCntReg} :
    (regAddr == ADDR_COUNT) ? {16'h0, countReg} : RST_WORD;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stateReg <= ST_IDLE;
      kindReg <= PDP_VIDEO;
      idxReg <= 8'h00;
      dataReg <= 8'h00;
    end else begin
      stateReg <= stateNext;
      kindReg <= kindNext;
      idxReg <= idxNext;
      dataReg <= ifc.curByte;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      videoReg <= pdp_video_s'(19'h0);
      audioReg <= pdp_audio_s'(5'h0);
      hierReg <= pdp_hier_s'(22'h0);
      fmtReg <= RST_WORD;
    end else if (idle) begin
      if (wrVideo) begin
        videoReg <= pdp_video_s'(regWrData[18:0]);
      end
      if (wrAudio) begin
        audioReg <= pdp_audio_s'(regWrData[4:0]);
      end
      if (wrHier) begin
        hierReg <= pdp_hier_s'(regWrData[21:0]);
      end
      if (wrFmt) begin
        fmtReg <= regWrData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      extraCntReg <= 4'h0;
    end else if (clrExtra) begin
      extraCntReg <= 4'h0;
    end else if (pushExtra) begin
      extraCntReg <= extraCntReg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (pushExtra) begin
      extraMem[extraCntReg[2:0]] <= regWrData[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refusedReg <= 1'b0;
    end else if (refuseEvt) begin
      refusedReg <= 1'b1;
    end else if (clrRefused) begin
      refusedReg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      countReg <= RST_COUNT;
    end else if (done) begin
      countReg <= countReg + 16'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdReg <= RST_WORD;
    end else if (regRdStb) begin
      rdReg <= rdMux;
    end
  end

  assign regRdData = rdReg;
  assign outData = dataReg;
  assign outValid = sending;
  assign outFirst = sending && (idxReg == 8'h00);
  assign outLast = sending && lastByte;

  // checks
  sequence s_header;
    outValid && outFirst && (outData == pdp_tag(kindReg));
  endsequence

  sequence s_length;
    outValid && (idxReg == 8'h01) && (outData == ifc.descLen);
  endsequence

  a_tag_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    go |=> s_header)
    else $error("descriptor does not open with its tag");

  a_len_second: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_header ##0 outReady |=> s_length)
    else $error("length byte does not follow the tag");

  a_len_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    outLast |-> (idxReg == ifc.descLen + HDR_BYTES - 8'h01))
    else $error("byte count disagrees with length field");

  a_stall_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("byte changed while stalled");

  a_done_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    outLast && outReady |=> !outValid ##0 (countReg == $past(countReg) + 16'h1))
    else $error("descriptor end not reached after last byte");

  a_video_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_VIDEO |-> ifc.descLen ==
      (videoReg.legacyOnlyVideoFlag ? LEN_VIDEO_LONG : LEN_VIDEO_SHORT))
    else $error("video descriptor length wrong");

  a_constr_forced: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_VIDEO && idxReg == HDR_BYTES &&
    !videoReg.legacyOnlyVideoFlag |-> outData[1])
    else $error("constrained flag not forced");

  a_profile_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_VIDEO && idxReg == 8'h03 |->
      outData == videoReg.profLevel)
    else $error("profile and level not copied");

  a_audio_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_AUDIO && idxReg == HDR_BYTES |->
      outData[6:4] == {audioReg.audioIdentityBit, audioReg.layer} &&
      outData[2:0] == RSV3 && ifc.descLen == LEN_AUDIO)
    else $error("audio descriptor byte wrong");

  a_hier_layout: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_HIER && idxReg == 8'h03 |->
      outData == {RSV2, hierReg.layerIdx} && ifc.descLen == LEN_HIER)
    else $error("hierarchy layer index byte wrong");

  a_dup_refused: assert property (@(posedge clk_sys) disable iff (!nrst)
    startReq && idle && dupHier |=> !outValid && refusedReg)
    else $error("duplicate layer index was sent");

  a_fmt_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    outValid && kindReg == PDP_REG && idxReg == HDR_BYTES |->
      outData == fmtReg[31:24] &&
      ifc.descLen == LEN_REG_BASE + {4'h0, extraCntReg})
    else $error("registration descriptor header wrong");
endmodule

// [pdp_if.sv]
// field bundle between the sequencer and the byte packer
`timescale 1ns/1ns
interface pdp_if;
  import pdp_pkg::*;
  pdp_kind_e kind;
  pdp_video_s video;
  pdp_audio_s audio;
  pdp_hier_s hier;
  logic [31:0] fmtId;
  logic [3:0] extraCnt;
  logic [7:0] extraByte;
  logic [7:0] byteIdx;
  logic [7:0] curByte;
  logic [7:0] descLen;
  modport ctrl(output kind, video, audio, hier, fmtId, extraCnt, extraByte,
    byteIdx, input curByte, descLen);
  modport packer(input kind, video, audio, hier, fmtId, extraCnt, extraByte,
    byteIdx, output curByte, descLen);
endinterface

// [pdp_layer_check.sv]
// remembers hierarchy layer indices used in the current program
`timescale 1ns/1ns
module pdp_layer_check (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clearTable,
  input wire logic commit,
  input wire logic [5:0] queryIdx,
  output logic isDup
);
  import pdp_pkg::*;
  logic [63:0] usedReg;
  genvar i;
  generate
    for (i = 0; i < 64; i++) begin : g_entry
      wire hit = commit && (queryIdx == 6'(i));
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          usedReg[i] <= 1'b0;
        end else if (hit) begin
          usedReg[i] <= 1'b1;
        end else if (clearTable) begin
          usedReg[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign isDup = usedReg[queryIdx];
  a_commit_marks: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit |=> usedReg[$past(queryIdx)])
    else $error("committed layer index not marked used");
endmodule

// [pdp_pkg.sv]
// constants, field layouts and types of the descriptor builder
package pdp_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_VIDEO = 8'h08;
  localparam logic [7:0] ADDR_AUDIO = 8'h0c;
  localparam logic [7:0] ADDR_HIER = 8'h10;
  localparam logic [7:0] ADDR_FMT = 8'h14;
  localparam logic [7:0] ADDR_EXTRA = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1c;
  localparam int CTRL_START = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam int CTRL_NEWPROG = 3;
  localparam int CTRL_CLREXTRA = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam logic [7:0] TAG_VIDEO = 8'h02;
  localparam logic [7:0] LEN_VIDEO_SHORT = 8'h01;
  localparam logic [7:0] LEN_VIDEO_LONG = 8'h03;
  localparam logic [7:0] LEN_AUDIO = 8'h01;
  localparam logic [7:0] LEN_HIER = 8'h04;
  localparam logic [7:0] LEN_REG_BASE = 8'h04;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam logic [7:0] EXTRA_FIRST = 8'h06;
  localparam logic [3:0] EXTRA_MAX = 4'h8;
  localparam logic [4:0] RSV5 = 5'h1f;
  localparam logic [2:0] RSV3 = 3'h7;
  localparam logic [3:0] RSV4 = 4'hf;
  localparam logic [1:0] RSV2 = 2'h3;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [15:0] RST_COUNT = 16'h0;
  typedef enum logic [1:0] {PDP_VIDEO, PDP_AUDIO, PDP_HIER, PDP_REG} pdp_kind_e;
  typedef struct packed {
    logic rateExt;
    logic [1:0] chroma;
    logic [7:0] profLevel;
    logic still;
    logic constrained;
    logic legacyOnlyVideoFlag;
    logic [3:0] rateCode;
    logic multiRate;
  } pdp_video_s;
  typedef struct packed {
    logic variableRate;
    logic [1:0] layer;
    logic audioIdentityBit;
    logic freeFormat;
  } pdp_audio_s;
  typedef struct packed {
    logic [5:0] channel;
    logic [5:0] embedded;
    logic [5:0] layerIdx;
    logic [3:0] hierType;
  } pdp_hier_s;
  function automatic logic [7:0] pdp_tag(input pdp_kind_e k);
    pdp_tag = TAG_VIDEO + {6'h0, k};
  endfunction
endpackage

// [pdp_sink_model.sv]
// downstream descriptor consumer: takes bytes and checks framing
`timescale 1ns/1ns
module pdp_sink_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [7:0] outData,
  input wire logic outValid,
  input wire logic outFirst,
  input wire logic outLast,
  output logic outReady
);
  logic [7:0] rxBuf [0:15];
  logic phase;
  logic [4:0] rxCnt;
  logic [4:0] idxNow;
  logic tagKnown;
  logic take;
  int descCnt;
  int fmtErr;
  logic isVideo;
  logic isAudio;
  logic isHier;
  logic [3:0] hierKind;
  logic [5:0] chanNum;
  logic [7:0] minLen;
  logic [7:0] meaning;
  logic lenBad;
  // field meanings of the last descriptor taken
  assign isVideo = rxBuf[0] == 8'h02;
  assign isAudio = rxBuf[0] == 8'h03;
  assign isHier = rxBuf[0] == 8'h04;
  assign hierKind = rxBuf[2][3:0];
  assign chanNum = rxBuf[5][5:0];
  assign meaning[7] = isVideo && rxBuf[2][7];
  assign meaning[6] = isVideo && rxBuf[2][2];
  assign meaning[5] = isVideo && rxBuf[2][0];
  assign meaning[4] = isVideo && rxBuf[1] == 8'h03 && rxBuf[4][5];
  assign meaning[3] = isAudio && rxBuf[2][7];
  assign meaning[2] = isAudio && rxBuf[2][3];
  // base layer: embedded index is ignored
  assign meaning[1] = isHier && hierKind == 4'hf;
  // channel zero is the most robust one
  assign meaning[0] = isHier && chanNum == 6'h00;
  // shortest length that holds the fixed fields of each tag
  assign minLen = (isVideo || isAudio) ? 8'h01 :
    (isHier || rxBuf[0] == 8'h05) ? 8'h04 : 8'h00;
  assign lenBad = rxBuf[1] < minLen;
  assign take = outValid && outReady;
  assign idxNow = outFirst ? 5'h0 : rxCnt;
  // defined tags 2..18, transport variant so 14 and 17 allowed
  assign tagKnown = outData >= 8'h02 && outData <= 8'h12;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase <= 1'b0;
      outReady <= 1'b0;
      rxCnt <= 5'h0;
      descCnt <= 0;
      fmtErr <= 0;
    end else begin
      phase <= ~phase;
      // slow mode stalls every other cycle
      outReady <= slow ? phase : 1'b1;
      if (take && idxNow < 5'h10) begin
        rxBuf[idxNow[3:0]] <= outData;
        rxCnt <= idxNow + 5'h1;
      end
      if (take && ((outFirst && !tagKnown) || (!outFirst && rxCnt == 5'h0)))
      begin
        fmtErr <= fmtErr + 1;
      end
      if (take && outLast) begin
        descCnt <= descCnt + 1;
        rxCnt <= 5'h0;
        if ({3'h0, idxNow} + 8'h1 != rxBuf[1] + 8'h2 || lenBad) begin
          fmtErr <= fmtErr + 1;
        end
      end
    end
  end
endmodule

// [test_program_descriptor_parser.sv]
// self-checking bench for the descriptor builder
`timescale 1ns/1ns
module test_program_descriptor_parser;
  import pdp_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] f;
    logic [1:0] k;
    int n;
    logic [63:0] e;
    logic [7:0] m;
  } pdp_row_s;
  logic [7:0] seenMeaning;
  logic clk_sys;
  logic nrst;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWrStb;
  logic regRdStb;
  logic [31:0] regRdData;
  logic [7:0] outData;
  logic outValid;
  logic outFirst;
  logic outLast;
  logic outReady;
  logic slow;
  int err_count;
  int total_checks;
  pdp_row_s rows [0:6];
  assign seenMeaning = u_pdp_sink_model.meaning;

  pdp_descriptor_builder u_pdp_descriptor_builder (.clk_sys(clk_sys),
    .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .outData(outData), .outValid(outValid), .outFirst(outFirst),
    .outLast(outLast), .outReady(outReady));
  pdp_sink_model u_pdp_sink_model (.clk_sys(clk_sys), .nrst(nrst),
    .slow(slow), .outData(outData), .outValid(outValid),
    .outFirst(outFirst), .outLast(outLast), .outReady(outReady));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {32'h0, e}, {32'h0, regRdData});
  endtask

  task automatic wait_desc(input int want);
    int i;
    for (i = 0; i < 300 && u_pdp_sink_model.descCnt != want; i++) begin
      @(posedge clk_sys);
    end
    if (i == 300) begin
      $display("CHECK FAILED descriptors expected %0d seen %0d", want,
        u_pdp_sink_model.descCnt);
      err_count++;
      test_done();
    end
  endtask

  task automatic chk(input int first, input int n, input logic [63:0] e);
    for (int b = 0; b < n; b++) begin
      check("rx byte", {56'h0, e[(n-1-b)*8 +: 8]},
        {56'h0, u_pdp_sink_model.rxBuf[first+b]});
    end
  endtask

  initial begin
    nrst = 1'b0;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    slow = 1'b0;
    err_count = 0;
    total_checks = 0;
    rows[0] = '{ADDR_VIDEO, 32'h91, 2'h0, 3, 64'h0201c3, 8'ha0};
    rows[1] = '{ADDR_VIDEO, 32'h54826, 2'h0, 5, 64'h02031c487f, 8'h50};
    rows[2] = '{ADDR_AUDIO, 32'h19, 2'h1, 3, 64'h0301af, 8'h0c};
    rows[3] = '{ADDR_AUDIO, 32'h0, 2'h1, 3, 64'h030107, 8'h00};
    rows[4] = '{ADDR_HIER, 32'h3f56af, 2'h2, 6, 64'h0404ffead5ff, 8'h02};
    rows[5] = '{ADDR_HIER, 32'h1, 2'h2, 6, 64'h0404f1c0c0c0, 8'h01};
    rows[6] = '{ADDR_FMT, 32'h1234abcd, 2'h3, 6, 64'h05041234abcd, 8'h00};
    repeat (10) @(posedge clk_sys);
    check("valid in reset", 64'h0, {63'h0, outValid});
    nrst <= 1'b1;
    rd(ADDR_STAT, 32'h0);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_EXTRA, 32'h0);
    foreach (rows[r]) begin
      @(posedge clk_sys);
      slow <= r[0];
      wr(rows[r].a, rows[r].f);
      wr(ADDR_CTRL, {29'h0, rows[r].k, 1'b1});
      wait_desc(r + 1);
      chk(0, rows[r].n, rows[r].e);
      check("meaning", {56'h0, rows[r].m}, {56'h0, seenMeaning});
    end
    // registration with extra bytes, ninth push dropped
    for (int j = 1; j <= 9; j++) begin
      wr(ADDR_EXTRA, j);
    end
    rd(ADDR_EXTRA, 32'h8);
    wr(ADDR_FMT, 32'hc0de5a17);
    wr(ADDR_CTRL, 32'h7);
    wait_desc(8);
    chk(0, 6, 64'h050cc0de5a17);
    chk(6, 8, 64'h0102030405060708);
    wr(ADDR_CTRL, 32'h10);
    rd(ADDR_EXTRA, 32'h0);
    // start while busy is refused and leaves the running one intact
    wr(ADDR_AUDIO, 32'h19);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    wait_desc(9);
    chk(0, 3, 64'h0301af);
    rd(ADDR_STAT, 32'h2);
    wr(ADDR_STAT, 32'h2);
    rd(ADDR_STAT, 32'h0);
    // reused layer index in the same program is refused
    wr(ADDR_HIER, 32'h3f56af);
    wr(ADDR_CTRL, 32'h5);
    repeat (20) @(posedge clk_sys);
    check("no dup desc", 64'd9, u_pdp_sink_model.descCnt);
    rd(ADDR_STAT, 32'h2);
    wr(ADDR_STAT, 32'h2);
    wr(ADDR_CTRL, 32'h8);
    wr(ADDR_CTRL, 32'h5);
    wait_desc(10);
    chk(0, 6, 64'h0404ffead5ff);
    rd(ADDR_COUNT, 32'ha);
    rd(ADDR_CTRL, 32'h4);
    rd(8'h20, 32'h0);
    check("framing errors", 64'h0, u_pdp_sink_model.fmtErr);
    test_done();
  end
endmodule
